// >>> logic/ptmr_pkg.sv
// package: register map, fields, modes and timing constants of the prescaled timer
`default_nettype none
package ptmr_pkg;
  // =========================================================
  // register offsets (byte addresses, one word each)
  localparam logic [3:0] PTMR_OFS_MODE = 4'h0; // timer_mode_control
  localparam logic [3:0] PTMR_OFS_PRE = 4'h4; // prescaler_register
  localparam logic [3:0] PTMR_OFS_TMR = 4'h8; // timer register
  localparam logic [3:0] PTMR_OFS_PIN = 4'hc; // serial_pin_control (input_pin_select, source)
  localparam logic [3:0] PTMR_OFS_IRQ = 4'h0; // status word index base for irq flags
  localparam logic [3:0] PTMR_OFS_STAT = 4'h0;
  // =========================================================
  // mode control field positions
  localparam int PTMR_B_MOD0 = 0;
  localparam int PTMR_B_MOD1 = 1;
  localparam int PTMR_B_EDGE = 3;
  localparam int PTMR_B_START = 7;
  localparam int PTMR_B_INVOUT = 2;
  localparam int PTMR_B_MOD2 = 4;
  localparam int PTMR_B_MEDGE = 5;
  localparam int PTMR_B_UNDF = 6;
  // pin control field positions
  localparam int PTMR_B_PINSEL = 0;
  localparam int PTMR_B_SRC0 = 1;
  localparam int PTMR_B_UIRQ = 4;
  localparam int PTMR_B_XIRQ = 5;
  // reset values
  localparam logic [7:0] PTMR_RST_MODE = 8'h00;
  localparam logic [7:0] PTMR_RST_CNT = 8'hff;
  localparam logic [7:0] PTMR_RST_PIN = 8'h00;
  // =========================================================
  // count source divider: clock_div1, clock_div2, clock_div8, ring_osc_clock stand-in
  localparam int PTMR_DIV_RING = 16;
  localparam logic [31:0] PTMR_BUS_WAIT = 32'h1;
  typedef enum logic [1:0] {
    PTMR_TIMER = 2'b00,
    PTMR_PULSE = 2'b01,
    PTMR_EVENT = 2'b10,
    PTMR_WIDTH = 2'b11
  } ptmr_mode_e;
  // pending write pipeline for writes while counting
  typedef enum logic [1:0] {
    PTMR_WR_IDLE = 2'b00,
    PTMR_WR_RELOAD = 2'b01,
    PTMR_WR_XFER = 2'b10,
    PTMR_WR_RESUME = 2'b11
  } ptmr_wr_e;
  // avalon request bundle
  typedef struct packed {
    logic read;
    logic write;
    logic [3:0] address;
    logic [7:0] writedata;
  } ptmr_req_s;
  // one reload/counter pair
  typedef struct packed {
    logic [7:0] reload;
    logic [7:0] count;
  } ptmr_cnt_s;
endpackage : ptmr_pkg
`default_nettype wire

// >>> logic/ptmr_sync.sv
// three flop synchroniser with agreement filter for pin inputs
`default_nettype none
module ptmr_sync
  import ptmr_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // pin side
  input wire logic pin_in,
  // filtered level
  output logic level
);
  logic s1_r;
  logic s2_r;
  logic s3_r;
  logic level_r;
  // =========================================================
  // chain: first flop is read by the second only
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
      level_r <= 1'b0;
    end else begin
      s1_r <= pin_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) level_r <= s3_r; // change counts once two and three agree
    end
  end
  assign level = level_r;
endmodule // ptmr_sync
`default_nettype wire

// >>> logic/ptmr_top.sv
// prescaled 8-bit timer: timer, pulse output, event counter, pulse width modes
//
// The register offsets and the Avalon-MM register port are this design's own decisions.
`default_nettype none
//
// Contract
// - eight-bit down timer behind eight-bit prescaler, each reload register plus counter
// - edge polarity bit zero picks rising edge, one picks falling edge
// - pulse output mode counts internal source, toggles primary output at underflow
// - counter decrements, reloads at underflow and keeps counting
// - overall division is one over (prescaler+1)(timer+1)
// - start flag one runs counting, zero stops it, in every mode
// - timer interrupt request on each timer underflow in all modes
// - reads of timer and prescaler return live counts
// - write while stopped loads both reload register and counter
// - write while counting: reload at next input, counter at second, resume third
// - edge polarity bit sets output level when pulse output starts
// - writing timer register returns output to its starting level
// - inverted output bit drives secondary pin with inverse, else pin stays gpio
// - event mode decrements on selected active edge of external input
// - pin select bit picks external input pin a or b
// - width mode counts only while input high, or only while low
// - width mode raises external interrupt on edge ending measurement
// - rewriting edge polarity may set external interrupt flag
// - timer mode uses edge polarity only for external interrupt polarity
module ptmr_top
  import ptmr_pkg::*;
#(
  parameter int DATA_W = 8
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // avalon-mm slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // pins
  input wire logic timer_input_pin_a,
  input wire logic timer_input_pin_b,
  output logic pulse_out,
  output logic pulse_out_oe,
  output logic timer_io_pin_out,
  output logic timer_io_pin_oe,
  // interrupt requests
  output logic timer_irq,
  output logic external_input_interrupt
);
  // =========================================================
  // registers
  logic [7:0] mode_r;
  logic [7:0] pin_r;
  ptmr_cnt_s pre_r;
  ptmr_cnt_s tmr_r;
  logic [7:0] pre_wr_r;
  logic [7:0] tmr_wr_r;
  logic pre_pend_r;
  logic tmr_pend_r;
  ptmr_wr_e wr_st_r;
  logic out_r;
  logic uirq_r;
  logic xirq_r;
  logic [3:0] div_r;
  logic in_prev_r;
  logic ack_r;
  logic [31:0] rdata_r;
  ptmr_req_s req;
  // =========================================================
  // field decode
  ptmr_mode_e mode;
  logic start;
  logic edge_pol;
  logic inv_en;
  logic in_lvl;
  logic in_a;
  logic in_b;
  logic src_tick;
  logic in_rise;
  logic in_fall;
  logic act_edge;
  logic end_edge;
  logic cnt_tick;
  logic pre_unf;
  logic tmr_unf;
  logic wr_hit;
  logic wr_mode;
  logic wr_pre;
  logic wr_tmr;
  logic wr_pin;
  logic running;
  logic bus_req;
  logic wr_cnt;
  logic rd_take;
  logic [7:0] rd_byte;
  logic [7:0] pre_dec_nxt;
  logic [7:0] tmr_dec_nxt;
  logic out_home;
  logic uirq_clr;
  logic xirq_clr;
  logic xirq_set;
  assign req = '{read: avs_read, write: avs_write, address: avs_address, writedata: avs_writedata[7:0]};
  assign mode = ptmr_mode_e'({mode_r[PTMR_B_MOD1], mode_r[PTMR_B_MOD0]});
  assign start = mode_r[PTMR_B_START];
  assign edge_pol = mode_r[PTMR_B_EDGE];
  assign inv_en = mode_r[PTMR_B_INVOUT];
  // =========================================================
  // input pin synchronisers and selection
  ptmr_sync u_sync_a (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .pin_in(timer_input_pin_a),
    .level(in_a)
  );
  ptmr_sync u_sync_b (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .pin_in(timer_input_pin_b),
    .level(in_b)
  );
  // selected input, already synchronised
  assign in_lvl = pin_r[PTMR_B_PINSEL] ? in_b : in_a;
  assign in_rise = in_lvl & ~in_prev_r;
  assign in_fall = ~in_lvl & in_prev_r;
  assign act_edge = edge_pol ? in_fall : in_rise;
  // measurement ends when the counted level goes away
  assign end_edge = edge_pol ? in_rise : in_fall;
  // =========================================================
  // internal count source from divider, selected by pin_r bits
  function automatic logic src_sel(input logic [1:0] sel, input logic [3:0] div);
    case (sel)
      2'b00: src_sel = 1'b1;
      2'b01: src_sel = div[0];
      2'b10: src_sel = (div[2:0] == 3'h7);
      default: src_sel = (div == 4'hf);
    endcase
  endfunction
  assign src_tick = src_sel(pin_r[PTMR_B_SRC0 +: 2], div_r);
  // count source per mode
  always_comb begin
    case (mode)
      PTMR_EVENT: cnt_tick = act_edge;
      PTMR_WIDTH: cnt_tick = src_tick & (in_lvl == ~edge_pol);
      default: cnt_tick = src_tick;
    endcase
  end
  assign running = start && (wr_st_r == PTMR_WR_IDLE);
  assign pre_unf = running && cnt_tick && (pre_r.count == 8'h00);
  assign tmr_unf = pre_unf && (tmr_r.count == 8'h00);
  // next counts while running: reload at zero, else step down
  assign pre_dec_nxt = pre_unf ? pre_r.reload : pre_r.count - 8'h01;
  assign tmr_dec_nxt = tmr_unf ? tmr_r.reload : tmr_r.count - 8'h01;
  // =========================================================
  // bus decode; a write acts in the cycle waitrequest is low
  function automatic logic at_ofs(input logic [3:0] addr, input logic [3:0] ofs);
    at_ofs = (addr == ofs);
  endfunction
  assign bus_req = req.read || req.write;
  assign wr_hit = req.write && ack_r;
  assign wr_mode = wr_hit && at_ofs(req.address, PTMR_OFS_MODE);
  assign wr_pre = wr_hit && at_ofs(req.address, PTMR_OFS_PRE);
  assign wr_tmr = wr_hit && at_ofs(req.address, PTMR_OFS_TMR);
  assign wr_pin = wr_hit && at_ofs(req.address, PTMR_OFS_PIN);
  assign wr_cnt = wr_pre || wr_tmr;
  assign rd_take = req.read && !ack_r;
  // =========================================================
  // free divider and input history
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      div_r <= 4'h0;
      in_prev_r <= 1'b0;
    end else begin
      div_r <= div_r + 4'h1;
      in_prev_r <= in_lvl;
    end
  end
  // =========================================================
  // mode and pin control registers
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      mode_r <= PTMR_RST_MODE;
      pin_r <= PTMR_RST_PIN;
    end else begin
      if (wr_mode) mode_r <= req.writedata;
      if (wr_pin) pin_r <= req.writedata;
    end
  end
  // =========================================================
  // write sequencing while counting: reload, transfer, resume
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_st_r <= PTMR_WR_IDLE;
      pre_wr_r <= 8'h00;
      tmr_wr_r <= 8'h00;
      pre_pend_r <= 1'b0;
      tmr_pend_r <= 1'b0;
    end else begin
      if (wr_cnt && start) begin
        if (wr_pre) pre_wr_r <= req.writedata;
        if (wr_tmr) tmr_wr_r <= req.writedata;
        pre_pend_r <= pre_pend_r | wr_pre;
        tmr_pend_r <= tmr_pend_r | wr_tmr;
        wr_st_r <= PTMR_WR_RELOAD;
      end else if (!start) begin
        wr_st_r <= PTMR_WR_IDLE;
        pre_pend_r <= 1'b0;
        tmr_pend_r <= 1'b0;
      end else if (cnt_tick) begin
        case (wr_st_r)
          PTMR_WR_RELOAD: wr_st_r <= PTMR_WR_XFER;
          PTMR_WR_XFER: wr_st_r <= PTMR_WR_RESUME;
          PTMR_WR_RESUME: begin
            wr_st_r <= PTMR_WR_IDLE;
            pre_pend_r <= 1'b0;
            tmr_pend_r <= 1'b0;
          end
          default: wr_st_r <= PTMR_WR_IDLE;
        endcase
      end
    end
  end
  // =========================================================
  // prescaler and timer counters
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      pre_r <= '{reload: PTMR_RST_CNT, count: PTMR_RST_CNT};
      tmr_r <= '{reload: PTMR_RST_CNT, count: PTMR_RST_CNT};
    end else if (!start) begin
      if (wr_pre) pre_r <= '{reload: req.writedata, count: req.writedata};
      if (wr_tmr) tmr_r <= '{reload: req.writedata, count: req.writedata};
    end else if (wr_st_r == PTMR_WR_RELOAD && cnt_tick) begin
      if (pre_pend_r) pre_r.reload <= pre_wr_r;
      if (tmr_pend_r) tmr_r.reload <= tmr_wr_r;
    end else if (wr_st_r == PTMR_WR_XFER && cnt_tick) begin
      if (pre_pend_r) pre_r.count <= pre_r.reload;
      if (tmr_pend_r) tmr_r.count <= tmr_r.reload;
    end else if (running && cnt_tick) begin
      pre_r.count <= pre_dec_nxt;
      if (pre_unf) tmr_r.count <= tmr_dec_nxt;
    end
  end
  // =========================================================
  // pulse output level
  // home level on timer write, outside pulse mode, or mode write while stopped
  assign out_home = (mode != PTMR_PULSE) || wr_tmr || (wr_mode && !start);
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      out_r <= 1'b0;
    end else if (out_home) begin
      out_r <= edge_pol;
    end else if (tmr_unf) begin
      out_r <= ~out_r;
    end
  end
  // =========================================================
  // interrupt request flags; set wins over software clear
  // a zero written to a flag bit clears it, a one leaves it
  assign uirq_clr = wr_pin && !req.writedata[PTMR_B_UIRQ];
  assign xirq_clr = wr_pin && !req.writedata[PTMR_B_XIRQ];
  // end of measurement, timer-mode edge, or polarity rewrite at high input
  assign xirq_set = (mode == PTMR_WIDTH ? end_edge : (mode == PTMR_TIMER && act_edge))
    | (wr_mode && (req.writedata[PTMR_B_EDGE] != edge_pol) && in_lvl);
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      uirq_r <= 1'b0;
      xirq_r <= 1'b0;
    end else begin
      uirq_r <= tmr_unf | (uirq_r & ~uirq_clr);
      xirq_r <= xirq_set | (xirq_r & ~xirq_clr);
    end
  end
  // =========================================================
  // read data and one-wait-state handshake
  // read byte by address; latched once per read so it stands until the next
  assign rd_byte = at_ofs(req.address, PTMR_OFS_MODE) ? mode_r
    : at_ofs(req.address, PTMR_OFS_PRE) ? pre_r.count
    : at_ofs(req.address, PTMR_OFS_TMR) ? tmr_r.count
    : at_ofs(req.address, PTMR_OFS_PIN) ? {2'b00, xirq_r, uirq_r, 1'b0, pin_r[2:0]}
    : 8'h00;
  // acknowledge in the second cycle of every request
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ack_r <= 1'b0;
      rdata_r <= 32'h0;
    end else begin
      ack_r <= bus_req && !ack_r;
      if (rd_take) rdata_r <= {24'h0, rd_byte};
    end
  end
  assign avs_waitrequest = bus_req && !ack_r;
  assign avs_readdata = rdata_r;
  // =========================================================
  // pin drivers
  assign pulse_out = out_r;
  assign pulse_out_oe = (mode == PTMR_PULSE);
  assign timer_io_pin_out = ~out_r;
  assign timer_io_pin_oe = (mode == PTMR_PULSE) && inv_en;
  assign timer_irq = uirq_r;
  assign external_input_interrupt = xirq_r;
endmodule // ptmr_top
`default_nettype wire

// >>> sim/ptmr_chk.sv
// checker: port-level properties of the prescaled timer
`default_nettype none
module ptmr_chk (
  // clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // bus
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // pins and requests
  input wire logic pulse_out,
  input wire logic pulse_out_oe,
  input wire logic timer_io_pin_out,
  input wire logic timer_io_pin_oe,
  input wire logic timer_irq,
  input wire logic external_input_interrupt
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  // ====
  // bus timing and data
  chk_wait_once: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("wait state count wrong");
  chk_upper_zero: assert property (avs_readdata[31:8] == 24'h0)
    else $error("read data above byte lane");
  chk_data_stands: assert property (!avs_read && !avs_write && !$past(avs_read) |-> $stable(avs_readdata))
    else $error("read data moved while idle");
  // ====
  // pulse pins
  chk_io_inverse: assert property (timer_io_pin_oe |-> timer_io_pin_out != pulse_out)
    else $error("secondary pin not inverse");
  chk_io_oe_mode: assert property (timer_io_pin_oe |-> pulse_out_oe)
    else $error("secondary pin driven outside pulse mode");
  chk_toggle_irq: assert property (pulse_out_oe && $past(pulse_out_oe) && $changed(pulse_out)
    && !$past(avs_write) && !$past(avs_write, 2) |-> ##[0:1] timer_irq)
    else $error("toggle without underflow request");
  // ====
  // requests stay until cleared by a write
  chk_irq_sticky: assert property (timer_irq && !avs_write |=> timer_irq)
    else $error("timer request dropped");
  chk_ext_sticky: assert property (external_input_interrupt && !avs_write |=> external_input_interrupt)
    else $error("external request dropped");
endmodule // ptmr_chk
bind ptmr_top ptmr_chk u_ptmr_chk (.ref_clk(ref_clk), .arst_n(arst_n), .avs_read(avs_read),
  .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .pulse_out(pulse_out), .pulse_out_oe(pulse_out_oe), .timer_io_pin_out(timer_io_pin_out),
  .timer_io_pin_oe(timer_io_pin_oe), .timer_irq(timer_irq),
  .external_input_interrupt(external_input_interrupt));
`default_nettype wire

// >>> sim/ptmr_pulse_src.sv
// partner: external pulse source on the two timer input pins
`default_nettype none
module ptmr_pulse_src (
  // clock
  input wire logic ref_clk,
  // pins
  output logic pin_a,
  output logic pin_b
);
  timeunit 1ns;
  timeprecision 100ps;
  // pins idle low between bursts
  initial begin
    pin_a = 1'b0;
    pin_b = 1'b0;
  end
  // one pin to a level, just after an edge
  task automatic set_pin(input bit on_b, input bit lvl);
    @(posedge ref_clk);
    pin_a <= on_b ? pin_a : lvl;
    pin_b <= on_b ? lvl : pin_b;
  endtask
  // k pulses, levels held well past the input filter; tail leaves pin high
  task automatic burst(input bit on_b, input int k, input int hi, input bit tail);
    for (int i = 0; i < k; i++) begin
      set_pin(on_b, 1'b1);
      repeat (hi) @(posedge ref_clk);
      set_pin(on_b, 1'b0);
      repeat (6) @(posedge ref_clk);
    end
    if (tail) set_pin(on_b, 1'b1);
  endtask
endmodule // ptmr_pulse_src
`default_nettype wire

// >>> sim/tb_ptmr_top.sv
// testbench: bus tasks, pulse source and reference counts for the timer
`default_nettype none
module tb_ptmr_top import ptmr_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk = 1'b0, arst_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0, ed = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, q, q2;
  logic avs_waitrequest, pin_a, pin_b, pulse_out, pulse_out_oe, io_out, io_oe, timer_irq, ext_irq;
  int n_errors = 0, tests_run = 0, cyc = 0, seed = 34, n, m, t;
  `define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin n_errors++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp); end end
  // ====
  // clock, design, pulse source
  always #2.5 ref_clk = ~ref_clk;
  ptmr_top u_ptmr_top (.ref_clk(ref_clk), .arst_n(arst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .timer_input_pin_a(pin_a), .timer_input_pin_b(pin_b),
    .pulse_out(pulse_out), .pulse_out_oe(pulse_out_oe), .timer_io_pin_out(io_out),
    .timer_io_pin_oe(io_oe), .timer_irq(timer_irq), .external_input_interrupt(ext_irq));
  ptmr_pulse_src u_ptmr_pulse_src (.ref_clk(ref_clk), .pin_a(pin_a), .pin_b(pin_b));
  // ====
  // verdict and hang guard
  task automatic report_and_stop();
    if (n_errors == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_errors++;
      report_and_stop();
    end
  end
  // ====
  // one avalon transfer, held until waitrequest is seen low
  task automatic bus(input logic we, input logic [3:0] a, input logic [7:0] d);
    logic w;
    @(posedge ref_clk);
    avs_read <= !we;
    avs_write <= we;
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    w = 1'b1;
    while (w) begin
      @(negedge ref_clk);
      w = (avs_waitrequest !== 1'b0);
      @(posedge ref_clk);
    end
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(negedge ref_clk);
  endtask
  // mode byte with the current edge polarity
  function automatic logic [7:0] md(input logic [7:0] b);
    return b | {4'h0, ed, 3'h0};
  endfunction
  // cycles until the primary output changes
  task automatic wait_chg(output int c);
    logic l;
    l = pulse_out;
    c = 0;
    while (pulse_out === l && c < 3000) begin
      @(negedge ref_clk);
      c++;
    end
  endtask
  // ====
  // main sequence
  initial begin
    logic [3:0] ofs[5];
    logic [7:0] rv[5];
    ofs = '{PTMR_OFS_MODE, PTMR_OFS_PRE, PTMR_OFS_TMR, PTMR_OFS_PIN, 4'h1};
    rv = '{PTMR_RST_MODE, PTMR_RST_CNT, PTMR_RST_CNT, PTMR_RST_PIN, 8'h00};
    repeat (4) @(posedge ref_clk);
    arst_n <= 1'b1;
    // reset values and the unmapped hole
    for (int i = 0; i < 5; i++) begin
      bus(1'b0, ofs[i], 8'h00);
      `CHK(q, {24'h0, rv[i]})
    end
    // pulse output, both start levels, random settings
    for (int i = 0; i < 2; i++) begin
      ed = i[0];
      n = 1 + ($random(seed) & 3);
      m = 1 + ($random(seed) & 7);
      bus(1'b1, PTMR_OFS_MODE, md(8'h05));
      bus(1'b1, PTMR_OFS_PRE, n[7:0]);
      bus(1'b1, PTMR_OFS_TMR, m[7:0]);
      bus(1'b0, PTMR_OFS_TMR, 8'h00);
      `CHK(q, 32'(m))
      `CHK(pulse_out, ed)
      `CHK({pulse_out_oe, io_oe, io_out}, {2'b11, ~ed})
      bus(1'b1, PTMR_OFS_MODE, md(8'h85));
      wait_chg(t);
      wait_chg(t);
      `CHK(t, (n + 1) * (m + 1))
      `CHK(timer_irq, 1'b1)
      bus(1'b1, PTMR_OFS_TMR, m[7:0]);
      `CHK(pulse_out, ed)
      bus(1'b1, PTMR_OFS_MODE, md(8'h05));
      bus(1'b0, PTMR_OFS_TMR, 8'h00);
      q2 = q;
      bus(1'b0, PTMR_OFS_TMR, 8'h00);
      `CHK(q, q2)
    end
    // clear requests, then live count in plain timer mode
    bus(1'b1, PTMR_OFS_PIN, 8'h00);
    `CHK(timer_irq, 1'b0)
    ed = 1'b0;
    bus(1'b1, PTMR_OFS_MODE, 8'h00);
    bus(1'b1, PTMR_OFS_PRE, 8'h00);
    bus(1'b1, PTMR_OFS_TMR, 8'hff);
    bus(1'b1, PTMR_OFS_MODE, 8'h80);
    bus(1'b0, PTMR_OFS_TMR, 8'h00);
    q2 = q;
    bus(1'b0, PTMR_OFS_TMR, 8'h00);
    `CHK(q != q2, 1'b1)
    // event counting, both edges, wrong pin first
    for (int i = 0; i < 2; i++) begin
      ed = i[0];
      bus(1'b1, PTMR_OFS_MODE, md(8'h02));
      bus(1'b1, PTMR_OFS_PRE, 8'h00);
      bus(1'b1, PTMR_OFS_TMR, 8'h20);
      bus(1'b1, PTMR_OFS_PIN, 8'h00);
      bus(1'b1, PTMR_OFS_MODE, md(8'h82));
      u_ptmr_pulse_src.burst(1'b1, 3, 6, 1'b0);
      bus(1'b0, PTMR_OFS_TMR, 8'h00);
      `CHK(q, 32'h20)
      bus(1'b1, PTMR_OFS_PIN, 8'h01);
      u_ptmr_pulse_src.burst(1'b1, 4, 6, 1'b1);
      repeat (10) @(negedge ref_clk);
      bus(1'b0, PTMR_OFS_TMR, 8'h00);
      `CHK(q, 32'(32'h1c - (1 - i)))
      u_ptmr_pulse_src.set_pin(1'b1, 1'b0);
      repeat (10) @(negedge ref_clk);
      bus(1'b1, PTMR_OFS_TMR, 8'h10);
      u_ptmr_pulse_src.burst(1'b1, 4, 6, 1'b0);
      repeat (10) @(negedge ref_clk);
      bus(1'b0, PTMR_OFS_TMR, 8'h00);
      `CHK(q, 32'h0f)
      bus(1'b1, PTMR_OFS_MODE, md(8'h02));
      u_ptmr_pulse_src.set_pin(1'b1, 1'b0);
    end
    // width measurement of one high pulse on pin b
    ed = 1'b0;
    bus(1'b1, PTMR_OFS_MODE, 8'h03);
    bus(1'b1, PTMR_OFS_TMR, 8'hff);
    bus(1'b1, PTMR_OFS_PIN, 8'h01);
    bus(1'b1, PTMR_OFS_MODE, 8'h83);
    u_ptmr_pulse_src.burst(1'b1, 1, 20, 1'b0);
    repeat (10) @(negedge ref_clk);
    bus(1'b0, PTMR_OFS_TMR, 8'h00);
    `CHK(q >= 32'he9 && q <= 32'hed, 1'b1)
    `CHK(ext_irq, 1'b1)
    report_and_stop();
  end
endmodule // tb_ptmr_top
`default_nettype wire
